// ### core/pmrg_pkg.sv
/*
  Package of the regulator and day-alarm register slice: register
  indexes, field layouts as packed structs, reset values.
  Assumes a 24-bit register word reached by register index.
*/
package pmrg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;

  // Register indexes, used directly as the port address
  localparam logic [7:0] OFS_DAY_ALARM = 8'h17;
  localparam logic [7:0] OFS_B1A_VOLT = 8'h18;
  localparam logic [7:0] OFS_B23_VOLT = 8'h19;
  localparam logic [7:0] OFS_B4_VOLT = 8'h1a;
  localparam logic [7:0] OFS_B5_VOLT = 8'h1b;
  localparam logic [7:0] OFS_MODE12 = 8'h1c;
  localparam logic [7:0] OFS_MODE345 = 8'h1d;
  localparam logic [7:0] OFS_LINEAR = 8'h1e;

  // Reset values
  localparam logic [14:0] DAY_ALARM_RST = 15'h7fff;
  localparam logic [3:0] MODE_RST = 4'ha;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [1:0] RAMP_RST = 2'h1;
  localparam logic PLL_EN_RST = 1'b1;
  localparam logic PLL_X_RST = 1'b0;
  localparam logic HOLD_OFF_RST = 1'b0;
  localparam logic [4:0] B4B_STBY_RST = 5'h00;
  localparam logic [1:0] B4B_HI_RST = 2'h0;
  localparam int NUM_BUCKS = 6;

  typedef struct packed {
    logic [5:0] stby;
    logic [5:0] norm;
  } pmrg_b1a_s;

  typedef struct packed {
    logic [4:0] b3Stby;
    logic [4:0] b3Norm;
    logic [5:0] b2Stby;
    logic [5:0] b2Norm;
  } pmrg_b23_s;

  typedef struct packed {
    logic [1:0] bHi;
    logic [4:0] bStby;
    logic [4:0] bNorm;
    logic [1:0] aHi;
    logic [4:0] aStby;
    logic [4:0] aNorm;
  } pmrg_b4_s;

  typedef struct packed {
    logic [4:0] stby;
    logic [4:0] norm;
  } pmrg_b5_s;

  // One buck's mode field with its memory-hold and user-off bits
  typedef struct packed {
    logic userOff;
    logic memHold;
    logic [3:0] opMode;
  } pmrg_mode_s;

  typedef struct packed {
    logic switcher_pll_multiplier;
    logic switcher_pll_enable;
    logic [1:0] ramp2;
    pmrg_mode_s b2;
    logic [1:0] ramp1;
    pmrg_mode_s b1a;
  } pmrg_mode12_s;

  typedef struct packed {
    pmrg_mode_s b5;
    pmrg_mode_s b4b;
    pmrg_mode_s b4a;
    pmrg_mode_s b3;
  } pmrg_mode345_s;

  typedef struct packed {
    logic [1:0] usb2;
    logic [1:0] pll;
    logic [2:0] gen2;
    logic [1:0] dac;
    logic [2:0] gen1;
  } pmrg_lin_s;

  localparam pmrg_lin_s LIN_RST = '0;

  typedef struct packed {
    logic [14:0] dayAlarm;
    pmrg_b1a_s b1a;
    pmrg_b23_s b23;
    pmrg_b4_s b4;
    pmrg_b5_s b5;
    pmrg_mode12_s mode12;
    pmrg_mode345_s mode345;
    pmrg_lin_s lin;
  } pmrg_cfg_s;

  // Voltage images the startup sequencer loads
  typedef struct packed {
    pmrg_b1a_s b1a;
    pmrg_b23_s b23;
    pmrg_b4_s b4;
    pmrg_b5_s b5;
  } pmrg_seq_s;

  typedef struct packed {
    pmrg_cfg_s cfg;
    logic [23:0] rdData;
    logic [1:0] porSync;
    logic [1:0] offSync;
    logic [5:0] pums0;
    logic [5:0] pums1;
  } pmrg_state_s;

endpackage : pmrg_pkg

// ### core/pmrg_regs.sv
/*
  Register slice for the day alarm and the buck and linear regulator
  settings of a power-management chip.
  Assumes a same-clock host port and sequencer strobe; the two reset
  pins and the mode-select pins are asynchronous and are synchronised.
*/
`timescale 1ns/10ps

module pmrg_regs #(
  parameter logic [3:0] APS_CODE = 4'ha
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic rtcPowerOnResetN,
  input wire logic offStateResetN,
  input wire logic [5:0] powerUpModeSelect,
  input wire logic seqLoad,
  input wire pmrg_pkg::pmrg_seq_s seqVoltage,
  input wire logic [7:0] regAddr,
  input wire logic [23:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [23:0] regRdData,
  output pmrg_pkg::pmrg_cfg_s cfg
);

  // A disabled buck must be told apart from auto pulse skip
  if (APS_CODE == pmrg_pkg::MODE_OFF) begin : gBadApsCode
    $error("APS_CODE must differ from the off code");
  end

  pmrg_pkg::pmrg_state_s state_reg;
  pmrg_pkg::pmrg_state_s state_next;

  // Builds the 24-bit read image; unused positions stay zero
  function automatic logic [23:0] readWord(
    input pmrg_pkg::pmrg_cfg_s c,
    input logic [7:0] a
  );
    logic [23:0] w;
    w = 24'h000000;
    case (a)
      pmrg_pkg::OFS_DAY_ALARM: w = {9'h000, c.dayAlarm};
      pmrg_pkg::OFS_B1A_VOLT: w = {12'h000, c.b1a};
      pmrg_pkg::OFS_B23_VOLT: begin
        w = {1'b0, c.b23.b3Stby, 1'b0, c.b23.b3Norm,
             c.b23.b2Stby, c.b23.b2Norm};
      end
      pmrg_pkg::OFS_B4_VOLT: w = c.b4;
      pmrg_pkg::OFS_B5_VOLT: begin
        w = {9'h000, c.b5.stby, 5'h00, c.b5.norm};
      end
      pmrg_pkg::OFS_MODE12: begin
        w = {c.mode12.switcher_pll_multiplier, c.mode12.switcher_pll_enable, c.mode12.ramp2,
             c.mode12.b2, 6'h00, c.mode12.ramp1,
             c.mode12.b1a};
      end
      pmrg_pkg::OFS_MODE345: w = c.mode345;
      pmrg_pkg::OFS_LINEAR: begin
        w = {11'h000, c.lin.usb2, c.lin.pll, c.lin.gen2,
             c.lin.dac, 1'b0, c.lin.gen1};
      end
      default: w = 24'h000000;
    endcase
    return w;
  endfunction : readWord

  // Mode value that the sequencer gives a buck from its select pin
  function automatic logic [3:0] seqMode(input logic enabled);
    return enabled ? APS_CODE : pmrg_pkg::MODE_OFF;
  endfunction : seqMode

  // Next-state logic: host write, then sequencer, then the resets,
  // so that a reset overrides a same-cycle write to the bits it loads
  always_comb begin
    state_next = state_reg;
    // Asynchronous pins pass two flops before any use
    state_next.porSync = {state_reg.porSync[0], ~rtcPowerOnResetN};
    state_next.offSync = {state_reg.offSync[0], ~offStateResetN};
    state_next.pums0 = powerUpModeSelect;
    state_next.pums1 = state_reg.pums0;
    // Read data stands for one cycle only
    state_next.rdData = regRead ?
      readWord(state_reg.cfg, regAddr) : 24'h000000;

    // Host writes; unused bits are simply not stored
    if (regWrite) begin
      case (regAddr)
        pmrg_pkg::OFS_DAY_ALARM: begin
          state_next.cfg.dayAlarm = regWrData[14:0];
        end
        pmrg_pkg::OFS_B1A_VOLT: begin
          state_next.cfg.b1a = regWrData[11:0];
        end
        pmrg_pkg::OFS_B23_VOLT: begin
          state_next.cfg.b23.b2Norm = regWrData[5:0];
          state_next.cfg.b23.b2Stby = regWrData[11:6];
          state_next.cfg.b23.b3Norm = regWrData[16:12];
          state_next.cfg.b23.b3Stby = regWrData[22:18];
        end
        pmrg_pkg::OFS_B4_VOLT: begin
          state_next.cfg.b4 = regWrData;
        end
        pmrg_pkg::OFS_B5_VOLT: begin
          state_next.cfg.b5.norm = regWrData[4:0];
          state_next.cfg.b5.stby = regWrData[14:10];
        end
        pmrg_pkg::OFS_MODE12: begin
          state_next.cfg.mode12.b1a = regWrData[5:0];
          state_next.cfg.mode12.ramp1 = regWrData[7:6];
          state_next.cfg.mode12.b2 = regWrData[19:14];
          state_next.cfg.mode12.ramp2 = regWrData[21:20];
          state_next.cfg.mode12.switcher_pll_enable = regWrData[22];
          state_next.cfg.mode12.switcher_pll_multiplier = regWrData[23];
        end
        pmrg_pkg::OFS_MODE345: begin
          state_next.cfg.mode345 = regWrData;
        end
        pmrg_pkg::OFS_LINEAR: begin
          state_next.cfg.lin.gen1 = regWrData[2:0];
          state_next.cfg.lin.dac = regWrData[5:4];
          state_next.cfg.lin.gen2 = regWrData[8:6];
          state_next.cfg.lin.pll = regWrData[10:9];
          state_next.cfg.lin.usb2 = regWrData[12:11];
        end
        default: begin
          state_next.cfg = state_next.cfg; // Unmapped: ignored
        end
      endcase
    end

    // Startup sequencer loads all four voltage registers and the modes
    if (seqLoad) begin
      state_next.cfg.b1a = seqVoltage.b1a;
      state_next.cfg.b23 = seqVoltage.b23;
      state_next.cfg.b4 = seqVoltage.b4;
      state_next.cfg.b5 = seqVoltage.b5;
      state_next.cfg.mode12.b1a.opMode =
        seqMode(state_reg.pums1[0]);
      state_next.cfg.mode12.b2.opMode = seqMode(state_reg.pums1[1]);
      state_next.cfg.mode345.b3.opMode = seqMode(state_reg.pums1[2]);
      state_next.cfg.mode345.b4a.opMode = seqMode(state_reg.pums1[3]);
      state_next.cfg.mode345.b4b.opMode = seqMode(state_reg.pums1[4]);
      state_next.cfg.mode345.b5.opMode = seqMode(state_reg.pums1[5]);
    end

    // Off-state reset clears only the hold and user-off bits
    if (state_reg.offSync[1]) begin
      state_next.cfg.mode12.b1a.memHold = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode12.b1a.userOff = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode12.b2.memHold = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode12.b2.userOff = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b3.memHold = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b3.userOff = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b4a.memHold = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b4a.userOff = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b4b.memHold = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b4b.userOff = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b5.memHold = pmrg_pkg::HOLD_OFF_RST;
      state_next.cfg.mode345.b5.userOff = pmrg_pkg::HOLD_OFF_RST;
    end

    // System reset; voltages without a reset keep their value. The reset-pin
    // synchronisers keep running, so a reset pin is never lost under it
    if (reset) begin
      state_next.cfg.mode12.b1a.opMode = pmrg_pkg::MODE_RST;
      state_next.cfg.mode12.b2.opMode = pmrg_pkg::MODE_RST;
      state_next.cfg.mode345.b3.opMode = pmrg_pkg::MODE_RST;
      state_next.cfg.mode345.b4a.opMode = pmrg_pkg::MODE_RST;
      state_next.cfg.mode345.b4b.opMode = pmrg_pkg::MODE_RST;
      state_next.cfg.mode345.b5.opMode = pmrg_pkg::MODE_RST;
      state_next.cfg.mode12.ramp1 = pmrg_pkg::RAMP_RST;
      state_next.cfg.mode12.ramp2 = pmrg_pkg::RAMP_RST;
      state_next.cfg.mode12.switcher_pll_enable = pmrg_pkg::PLL_EN_RST;
      state_next.cfg.mode12.switcher_pll_multiplier = pmrg_pkg::PLL_X_RST;
      state_next.cfg.b4.bStby = pmrg_pkg::B4B_STBY_RST;
      state_next.cfg.b4.bHi = pmrg_pkg::B4B_HI_RST;
      state_next.cfg.lin = pmrg_pkg::LIN_RST;
      state_next.rdData = 24'h000000;
      state_next.pums0 = 6'h00;
      state_next.pums1 = 6'h00;
    end

    // Only the RTC power-on reset restores the day alarm; a global
    // reset passes through the system reset and leaves it alone
    if (state_reg.porSync[1]) begin
      state_next.cfg.dayAlarm = pmrg_pkg::DAY_ALARM_RST;
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign regRdData = state_reg.rdData;
  assign cfg = state_reg.cfg;

  // Checks of the register behaviour
  sequence sB1aWrite;
    regWrite && regAddr == pmrg_pkg::OFS_B1A_VOLT && !seqLoad;
  endsequence

  sequence sB1aRead;
    regRead && regAddr == pmrg_pkg::OFS_B1A_VOLT && !seqLoad;
  endsequence

  a_day_alarm_por: assert property (
    @(posedge clk) state_reg.porSync[1]
      |=> cfg.dayAlarm == pmrg_pkg::DAY_ALARM_RST)
    else $error("day alarm not restored by RTC reset");

  a_day_alarm_keep: assert property (
    @(posedge clk) reset && !state_reg.porSync[1]
      |=> $stable(cfg.dayAlarm))
    else $error("day alarm changed by system reset");

  a_b1a_write_read: assert property (
    @(posedge clk) disable iff (reset)
      sB1aWrite ##1 sB1aRead
      |=> regRdData == {12'h000, $past(regWrData[11:0], 2)})
    else $error("buck 1A setting read back wrong");

  a_b23_reserved: assert property (
    @(posedge clk) disable iff (reset)
      regRead && regAddr == pmrg_pkg::OFS_B23_VOLT
      |=> !regRdData[17] && !regRdData[23])
    else $error("buck 2/3 unused bits not zero");

  a_b4b_reset: assert property (
    @(posedge clk) reset
      |=> cfg.b4.bStby == pmrg_pkg::B4B_STBY_RST
          && cfg.b4.bHi == pmrg_pkg::B4B_HI_RST)
    else $error("buck 4B standby or high not cleared");

  a_b5_reserved: assert property (
    @(posedge clk) disable iff (reset)
      regRead && regAddr == pmrg_pkg::OFS_B5_VOLT
      |=> regRdData[9:5] == 5'h00 && regRdData[23:15] == 9'h000)
    else $error("buck 5 unused bits not zero");

  a_mode_reset: assert property (
    @(posedge clk) reset
      |=> cfg.mode12.b1a.opMode == pmrg_pkg::MODE_RST
          && cfg.mode12.b2.opMode == pmrg_pkg::MODE_RST
          && cfg.mode345.b5.opMode == pmrg_pkg::MODE_RST)
    else $error("mode field not reset to default");

  a_mode_seq_load: assert property (
    @(posedge clk) disable iff (reset)
      seqLoad |=> cfg.mode345.b4b.opMode
        == seqMode($past(state_reg.pums1[4])))
    else $error("sequencer mode load wrong");

  a_hold_off_clear: assert property (
    @(posedge clk) state_reg.offSync[1]
      |=> !cfg.mode12.b1a.memHold && !cfg.mode12.b1a.userOff
          && !cfg.mode345.b3.memHold && !cfg.mode345.b5.userOff)
    else $error("hold or user-off bit not cleared");

  a_hold_keep_reset: assert property (
    @(posedge clk) reset && !state_reg.offSync[1]
      |=> $stable(cfg.mode12.b1a.memHold))
    else $error("hold bit changed by system reset");

  a_pll_ramp_reset: assert property (
    @(posedge clk) reset
      |=> cfg.mode12.switcher_pll_enable && !cfg.mode12.switcher_pll_multiplier
          && cfg.mode12.ramp1 == pmrg_pkg::RAMP_RST
          && cfg.mode12.ramp2 == pmrg_pkg::RAMP_RST)
    else $error("PLL or ramp field reset wrong");

  a_mode345_layout: assert property (
    @(posedge clk) disable iff (reset)
      regRead && regAddr == pmrg_pkg::OFS_MODE345
      |=> regRdData[21:18] == $past(cfg.mode345.b5.opMode)
          && regRdData[9:6] == $past(cfg.mode345.b4a.opMode))
    else $error("second mode register layout wrong");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (reset)
      regRead && (regAddr < pmrg_pkg::OFS_DAY_ALARM
        || regAddr > pmrg_pkg::OFS_LINEAR)
      |=> regRdData == 24'h000000)
    else $error("unmapped read not zero");

  a_linear_reset: assert property (
    @(posedge clk) reset |=> cfg.lin == pmrg_pkg::LIN_RST)
    else $error("linear settings not cleared");

  sequence sB4Write;
    regWrite && regAddr == pmrg_pkg::OFS_B4_VOLT && !seqLoad;
  endsequence

  sequence sB4Read;
    regRead && regAddr == pmrg_pkg::OFS_B4_VOLT && !seqLoad;
  endsequence

  sequence sMode12Write;
    regWrite && regAddr == pmrg_pkg::OFS_MODE12 && !seqLoad;
  endsequence

  a_b4_write_read: assert property (
    @(posedge clk) disable iff (reset)
      sB4Write ##1 sB4Read |=> regRdData == $past(regWrData, 2))
    else $error("buck 4 register read back wrong");

  a_mode12_write: assert property (
    @(posedge clk) disable iff (reset)
      sMode12Write |=> cfg.mode12.ramp1 == $past(regWrData[7:6])
          && cfg.mode12.ramp2 == $past(regWrData[21:20])
          && cfg.mode12.b2.opMode == $past(regWrData[17:14])
          && cfg.mode12.switcher_pll_enable == $past(regWrData[22]))
    else $error("first mode register write not stored");

  a_seq_volt_load: assert property (
    @(posedge clk) disable iff (reset)
      seqLoad |=> cfg.b1a == $past(seqVoltage.b1a)
          && cfg.b5 == $past(seqVoltage.b5))
    else $error("sequencer voltage load wrong");

  a_day_reserved: assert property (
    @(posedge clk) disable iff (reset)
      regRead && regAddr == pmrg_pkg::OFS_DAY_ALARM
      |=> regRdData[23:15] == 9'h000)
    else $error("day alarm unused bits not zero");

  a_mode12_unused: assert property (
    @(posedge clk) disable iff (reset)
      regRead && regAddr == pmrg_pkg::OFS_MODE12
      |=> regRdData[13:8] == 6'h00)
    else $error("first mode register unused bits not zero");

  a_lin_reserved: assert property (
    @(posedge clk) disable iff (reset)
      regRead && regAddr == pmrg_pkg::OFS_LINEAR
      |=> regRdData[23:13] == 11'h000 && !regRdData[3])
    else $error("linear register unused bits not zero");

endmodule : pmrg_regs

// ### dv/tb_pmrg_regs.sv
/*
  Self-checking bench of the day-alarm and regulator register slice.
  Assumes pmrg_pkg and pmrg_regs are compiled first; the bench drives
  every port itself and keeps a shadow copy of the eight registers.
*/
`timescale 1ns/10ps

module tb_pmrg_regs;
  // Writable bits of each register, index 0 is the day alarm
  localparam logic [23:0] WMASK [8] = '{24'h007fff, 24'h000fff,
    24'h7dffff, 24'hffffff, 24'h007c1f, 24'hffc0ff, 24'hffffff,
    24'h001ff7};
  localparam logic [23:0] HOLD12 = 24'h0c0030;
  localparam logic [23:0] HOLD345 = 24'hc30c30;
  localparam logic [23:0] RST12 = 24'h52804a;
  localparam logic [23:0] RST345 = 24'h28a28a;

  logic clk;
  logic reset;
  logic rtcPowerOnResetN;
  logic offStateResetN;
  logic [5:0] powerUpModeSelect;
  logic seqLoad;
  pmrg_pkg::pmrg_seq_s seqVoltage;
  logic [7:0] regAddr;
  logic [23:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [23:0] regRdData;
  pmrg_pkg::pmrg_cfg_s cfg;
  logic [23:0] mdl [8];
  logic [23:0] expQ [$];
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic live = 1'b0;
  logic rdPend = 1'b0;

  pmrg_regs pmrg_regs_inst (
    .clk(clk),
    .reset(reset),
    .rtcPowerOnResetN(rtcPowerOnResetN),
    .offStateResetN(offStateResetN),
    .powerUpModeSelect(powerUpModeSelect),
    .seqLoad(seqLoad),
    .seqVoltage(seqVoltage),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .cfg(cfg)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  function automatic logic [3:0] mc(input logic en);
    return en ? 4'ha : 4'h0;
  endfunction : mc

  // Host write; the shadow keeps only the bits that can store
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    if (a >= 8'h17 && a <= 8'h1e) begin
      mdl[a - 8'h17] = d & WMASK[a - 8'h17];
    end
  endtask : wr

  // Host read; the expected word is noted for the monitor
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    if (a >= 8'h17 && a <= 8'h1e) begin
      expQ.push_back(mdl[a - 8'h17]);
    end else begin
      expQ.push_back(24'h0);
    end
  endtask : rd

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      regRead <= 1'b0;
      regWrite <= 1'b0;
      seqLoad <= 1'b0;
    end
  endtask : idle

  // Reads every register back to back, then an unmapped index
  task automatic rdAll();
    for (int i = 0; i < 8; i++) begin
      rd(8'h17 + 8'(i));
    end
    rd(8'h20);
    idle(2);
  endtask : rdAll

  // Read data must appear only in the cycle after the strobe
  always @(negedge clk) begin
    if (rdPend) begin
      chk(regRdData, expQ.pop_front());
    end else if (live) begin
      chk(regRdData, 24'h0);
    end
    rdPend = regRead;
  end

  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    logic [95:0] r96;
    pmrg_pkg::pmrg_seq_s sv;
    logic [23:0] d;
    reset = 1'b1;
    rtcPowerOnResetN = 1'b0;
    offStateResetN = 1'b0;
    powerUpModeSelect = 6'h00;
    seqLoad = 1'b0;
    seqVoltage = '0;
    regAddr = 8'h00;
    regWrData = 24'h000000;
    regWrite = 1'b0;
    regRead = 1'b0;
    void'($urandom(57));
    repeat (12) @(posedge clk);
    rtcPowerOnResetN <= 1'b1;
    offStateResetN <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    live = 1'b1;
    mdl[0] = 24'h007fff;
    mdl[5] = RST12;
    mdl[6] = RST345;
    mdl[7] = 24'h000000;
    // Sequencer load: straps settle first, since they are synchronised
    powerUpModeSelect <= 6'($urandom);
    r96 = {$urandom, $urandom, $urandom};
    sv = r96[$bits(pmrg_pkg::pmrg_seq_s)-1:0];
    idle(4);
    @(posedge clk);
    seqLoad <= 1'b1;
    seqVoltage <= sv;
    idle(1);
    mdl[1] = {12'h000, sv.b1a};
    mdl[2] = {1'b0, sv.b23.b3Stby, 1'b0, sv.b23.b3Norm, sv.b23.b2Stby,
      sv.b23.b2Norm};
    mdl[3] = sv.b4;
    mdl[4] = {9'h000, sv.b5.stby, 5'h00, sv.b5.norm};
    mdl[5][3:0] = mc(powerUpModeSelect[0]);
    mdl[5][17:14] = mc(powerUpModeSelect[1]);
    mdl[6][3:0] = mc(powerUpModeSelect[2]);
    mdl[6][9:6] = mc(powerUpModeSelect[3]);
    mdl[6][15:12] = mc(powerUpModeSelect[4]);
    mdl[6][21:18] = mc(powerUpModeSelect[5]);
    rdAll();
    // All-ones first exposes read-only bits, then random words
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 9; i++) begin
        d = (r == 0) ? 24'hffffff : 24'($urandom);
        wr((i == 8) ? 8'h20 : 8'h17 + 8'(i), d);
      end
      rdAll();
    end
    // Read straight after write, for the write-then-read checks
    for (int i = 0; i < 2; i++) begin
      wr((i == 0) ? 8'h18 : 8'h1a, 24'($urandom));
      rd((i == 0) ? 8'h18 : 8'h1a);
    end
    idle(2);
    // System reset in mid-run spares alarm, unreset voltages and holds
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    mdl[3] = mdl[3] & 24'h01ffff;
    mdl[5] = (mdl[5] & HOLD12) | RST12;
    mdl[6] = (mdl[6] & HOLD345) | RST345;
    mdl[7] = 24'h000000;
    rdAll();
    // Off-state reset clears only hold and user-off bits
    @(posedge clk);
    offStateResetN <= 1'b0;
    idle(4);
    offStateResetN <= 1'b1;
    idle(3);
    mdl[5] = mdl[5] & ~HOLD12;
    mdl[6] = mdl[6] & ~HOLD345;
    rdAll();
    // Power-on reset of the clock domain restores the alarm
    @(posedge clk);
    rtcPowerOnResetN <= 1'b0;
    idle(4);
    rtcPowerOnResetN <= 1'b1;
    idle(3);
    mdl[0] = 24'h007fff;
    rdAll();
    chk({9'h000, cfg.dayAlarm}, 24'h007fff);
    chk(cfg.b4, mdl[3]);
    chk(cfg.mode345, mdl[6]);
    results();
  end
endmodule : tb_pmrg_regs
